// ---- inc/tmg_defs.vh ----
// Constants of the timing and management payload generator.
`ifndef TMG_DEFS_VH
`define TMG_DEFS_VH
`define TMG_A_CTRL        9'h000
`define TMG_A_STATUS      9'h001
`define TMG_A_CFG0        9'h002
`define TMG_A_CFG1        9'h003
`define TMG_A_CFG2        9'h004
`define TMG_A_GROUP       9'h005
`define TMG_A_EMIT_BASE   9'h080
`define TMG_A_XMTR_BASE   9'h100
`define TMG_CTRL_START    0
`define TMG_CTRL_CLR_ERR  1
`define TMG_VERSION_MAJOR 4'h0
`define TMG_VERSION_MINOR 4'h0
`define TMG_OVR_NONE      3'h0
`define TMG_OVR_FORCE     3'h7
`define TMG_COF_RESERVED  2'h2
`define TMG_NS_LIMIT      32'h3B9ACA00
`define TMG_PAYLOAD_TYPE  7'h4C
`define TMG_SOURCE_ID     32'h00000000
`define TMG_LEN_FIXED     16'h0020
`define TMG_SEG_LEN_RST   11'h578
`define TMG_CRC_POLY      16'h1021
`define TMG_CRC_INIT      16'hFFFF
`define TMG_HDR_BYTES     4'hC
`define TMG_ENTRY_BYTES   4'h8
`define TMG_TAIL_BYTES    4'h2
`endif

// ---- logic/tmg_check_word.v ----
// Byte-wide CRC-16 engine for the payload check word.
`default_nettype none
module tmg_check_word #(
    parameter [15:0] POLY = 16'h1021,
    parameter [15:0] INIT = 16'hFFFF
) (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        init,
    input  wire        en,
    input  wire [7:0]  data,
    output wire [15:0] crc
);
    reg  [15:0] crc_q;
    reg  [15:0] crc_d;
    integer     i;

    always @* begin
        crc_d = crc_q;
        for (i = 7; i >= 0; i = i - 1) begin
            if (crc_d[15] ^ data[i]) begin
                crc_d = {crc_d[14:0], 1'b0} ^ POLY;
            end else begin
                crc_d = {crc_d[14:0], 1'b0};
            end
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            crc_q <= 16'hFFFF;
        end else if (init) begin
            crc_q <= INIT;
        end else if (en) begin
            crc_q <= crc_d;
        end
    end

    assign crc = crc_q;
endmodule // tmg_check_word
`default_nettype wire

// ---- logic/tmg_payload_gen.v ----
// Timing and management payload generator with its register file.
`include "tmg_defs.vh"
`default_nettype none
module tmg_payload_gen (
    input  wire        core_clk,
    input  wire        reset,
    input  wire [8:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output wire [31:0] reg_rdata,
    input  wire [31:0] tai_seconds,
    input  wire [31:0] tai_nanosec,
    output wire [7:0]  out_data,
    output wire        out_valid,
    input  wire        out_ready,
    output wire        out_seg_start,
    output wire        out_marker,
    output wire        out_last,
    output wire [6:0]  seg_payload_type,
    output wire [31:0] seg_source_id,
    output wire        gen_busy
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CHECK = 3'h1;
    localparam [2:0] ST_HDR   = 3'h2;
    localparam [2:0] ST_EMIT  = 3'h3;
    localparam [2:0] ST_XMTR  = 3'h4;
    localparam [2:0] ST_REL   = 3'h5;
    localparam [2:0] ST_CRC   = 3'h6;

    reg  [31:0] emit_sec_q [0:63];
    reg  [31:0] emit_ns_q  [0:63];
    reg  [28:0] xmtr_w0_q  [0:63];
    reg  [5:0]  xmtr_w1_q  [0:63];
    reg  [29:0] cfg0_q;
    reg  [28:0] cfg1_q;
    reg  [6:0]  top_group_q;
    reg  [10:0] seg_len_q;
    reg  [6:0]  group_q;
    reg         err_q;
    reg  [2:0]  state_q;
    reg  [5:0]  idx_q;
    reg  [3:0]  left_q;
    reg  [95:0] sh_q;
    reg  [13:0] rls_q;
    reg  [10:0] seg_cnt_q;
    reg         first_seg_q;
    reg  [7:0]  out_data_q;
    reg         out_valid_q;
    reg         out_seg_start_q;
    reg         out_marker_q;
    reg         out_last_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         wr_ok;
    wire [15:0] crc;
    wire        adv;
    wire        emitting;
    wire        bad_order;
    wire [5:0]  num_emit;
    wire [5:0]  num_xmtr;
    wire [15:0] length;
    wire [95:0] hdr_word;
    wire [5:0]  idx_nx;
    integer     i;

    assign num_emit = cfg1_q[15:10];
    assign num_xmtr = cfg1_q[21:16];
    assign length   = `TMG_LEN_FIXED + {7'h00, num_emit, 3'h0}
                    + {7'h00, num_xmtr, 3'h0};
    assign hdr_word = {length, `TMG_VERSION_MAJOR, `TMG_VERSION_MINOR,
                       cfg0_q[3:0], cfg0_q[7:4],
                       cfg0_q[11:8], cfg0_q[15:12], cfg0_q[20:16],
                       cfg0_q[22:21], cfg0_q[29:23],
                       cfg1_q[7:0], cfg1_q[9:8], num_emit,
                       num_xmtr, group_q, cfg1_q[24:22],
                       cfg1_q[26:25], cfg1_q[28:27], 6'h3F};
    assign adv      = !out_valid_q || out_ready;
    assign emitting = (state_q >= ST_HDR) && adv;
    assign idx_nx   = idx_q + 6'h01;
    // Entries compare as one 64-bit time so seconds dominate nanoseconds.
    assign bad_order = {emit_sec_q[idx_q], emit_ns_q[idx_q]}
                     < {emit_sec_q[idx_q - 6'h01],
                        emit_ns_q[idx_q - 6'h01]};

    function legal_rep;
        input [3:0] v;
        begin
            legal_rep = v[0] && (v <= 4'h9);
        end
    endfunction

    function [95:0] emit_word;
        input [31:0] s;
        input [31:0] ns;
        begin
            emit_word = {s, ns, 32'hFFFFFFFF};
        end
    endfunction

    function [95:0] xmtr_word;
        input [28:0] w0;
        input [5:0]  w1;
        begin
            // Address leads the entry, then offset, level and filter index.
            xmtr_word = {w0[12:0], w0[28:13],
                         w1[3:0], w1[5:4],
                         29'h1FFFFFFF, 32'hFFFFFFFF};
        end
    endfunction

    tmg_check_word #(
        .POLY (`TMG_CRC_POLY),
        .INIT (`TMG_CRC_INIT)
    ) u_crc (
        .core_clk (core_clk),
        .reset    (reset),
        .init     (state_q == ST_IDLE),
        .en       (emitting && (state_q != ST_CRC)),
        .data     (sh_q[95:88]),
        .crc      (crc)
    );

    // Writes with values the structure may not carry are refused whole.
    always @* begin
        wr_ok = 1'b1;
        case (reg_addr)
            `TMG_A_CFG0: begin
                wr_ok = legal_rep(reg_wdata[3:0])
                     && legal_rep(reg_wdata[7:4]);
            end
            `TMG_A_CFG1: begin
                wr_ok = ((reg_wdata[24:22] == `TMG_OVR_NONE)
                      || (reg_wdata[24:22] == `TMG_OVR_FORCE))
                     && (reg_wdata[28:27] != `TMG_COF_RESERVED);
            end
            `TMG_A_CFG2: begin
                wr_ok = (reg_wdata[18:8] != 11'h000);
            end
            default: begin
                if (reg_addr[8:7] == 2'b01 && reg_addr[0]) begin
                    wr_ok = reg_wdata < `TMG_NS_LIMIT;
                end
            end
        endcase
    end

    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr)
            `TMG_A_STATUS: rdata_d = {29'h0, state_q != ST_IDLE, err_q, 1'b0};
            `TMG_A_CFG0:   rdata_d = {2'h0, cfg0_q};
            `TMG_A_CFG1:   rdata_d = {3'h0, cfg1_q};
            `TMG_A_CFG2:   rdata_d = {13'h0, seg_len_q, 1'b0, top_group_q};
            `TMG_A_GROUP:  rdata_d = {25'h0, group_q};
            default:       rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (i = 0; i < 64; i = i + 1) begin
                emit_sec_q[i] <= 32'h00000000;
                emit_ns_q[i]  <= 32'h00000000;
                xmtr_w0_q[i]  <= 29'h00000000;
                xmtr_w1_q[i]  <= 6'h00;
            end
            cfg0_q      <= 30'h00000011;
            cfg1_q      <= 29'h00000000;
            top_group_q <= 7'h00;
            seg_len_q   <= `TMG_SEG_LEN_RST;
            rdata_q     <= 32'h00000000;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 32'h00000000;
            // Tables stay writable while busy; software must not do so.
            if (reg_wr && wr_ok) begin
                case (reg_addr)
                    `TMG_A_CFG0: cfg0_q <= reg_wdata[29:0];
                    `TMG_A_CFG1: cfg1_q <= reg_wdata[28:0];
                    `TMG_A_CFG2: begin
                        top_group_q <= reg_wdata[6:0];
                        seg_len_q   <= reg_wdata[18:8];
                    end
                    default: begin
                        if (reg_addr[8:7] == 2'b01) begin
                            if (reg_addr[0]) begin
                                emit_ns_q[reg_addr[6:1]] <= reg_wdata;
                            end else begin
                                emit_sec_q[reg_addr[6:1]] <= reg_wdata;
                            end
                        end else if (reg_addr[8:7] == 2'b10) begin
                            if (reg_addr[0]) begin
                                xmtr_w1_q[reg_addr[6:1]] <= reg_wdata[5:0];
                            end else begin
                                xmtr_w0_q[reg_addr[6:1]] <= reg_wdata[28:0];
                            end
                        end
                    end
                endcase
            end
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q         <= ST_IDLE;
            idx_q           <= 6'h00;
            left_q          <= 4'h0;
            sh_q            <= 96'h0;
            rls_q           <= 14'h0000;
            group_q         <= 7'h00;
            err_q           <= 1'b0;
            seg_cnt_q       <= 11'h000;
            first_seg_q     <= 1'b0;
            out_data_q      <= 8'h00;
            out_valid_q     <= 1'b0;
            out_seg_start_q <= 1'b0;
            out_marker_q    <= 1'b0;
            out_last_q      <= 1'b0;
        end else begin
            if (out_valid_q && out_ready) begin
                out_valid_q <= 1'b0;
            end
            // A clear request clears the error only when no new one lands.
            if (reg_wr && reg_addr == `TMG_A_CTRL
                    && reg_wdata[`TMG_CTRL_CLR_ERR]) begin
                err_q <= 1'b0;
            end
            if (reg_wr && !wr_ok) begin
                err_q <= 1'b1;
            end
            if (emitting) begin
                out_data_q      <= (state_q == ST_CRC)
                                 ? (left_q[1] ? crc[15:8] : crc[7:0])
                                 : sh_q[95:88];
                out_valid_q     <= 1'b1;
                out_seg_start_q <= (seg_cnt_q == 11'h000);
                out_marker_q    <= (seg_cnt_q == 11'h000)
                                && first_seg_q;
                out_last_q      <= (state_q == ST_CRC) && (left_q == 4'h1);
                if (seg_cnt_q == seg_len_q - 11'h001) begin
                    seg_cnt_q   <= 11'h000;
                    first_seg_q <= 1'b0;
                end else begin
                    seg_cnt_q <= seg_cnt_q + 11'h001;
                end
                sh_q   <= {sh_q[87:0], 8'hFF};
                left_q <= left_q - 4'h1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (reg_wr && reg_addr == `TMG_A_CTRL
                            && reg_wdata[`TMG_CTRL_START]) begin
                        idx_q   <= 6'h01;
                        state_q <= ST_CHECK;
                        rls_q   <= {tai_seconds[3:0],
                                    tai_nanosec[29:20]};
                    end
                end
                ST_CHECK: begin
                    if (idx_q > num_emit || idx_q == 6'h00) begin
                        state_q     <= ST_HDR;
                        sh_q        <= hdr_word;
                        left_q      <= `TMG_HDR_BYTES;
                        seg_cnt_q   <= 11'h000;
                        first_seg_q <= 1'b1;
                    end else if (bad_order) begin
                        err_q   <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        idx_q <= idx_nx;
                    end
                end
                ST_HDR, ST_EMIT, ST_XMTR: begin
                    if (emitting && left_q == 4'h1) begin
                        left_q <= `TMG_ENTRY_BYTES;
                        if (state_q == ST_HDR) begin
                            state_q <= ST_EMIT;
                            idx_q   <= 6'h00;
                            sh_q    <= emit_word(emit_sec_q[0], emit_ns_q[0]);
                        end else if (state_q == ST_EMIT
                                     && idx_q != num_emit) begin
                            idx_q <= idx_nx;
                            sh_q  <= emit_word(emit_sec_q[idx_nx],
                                               emit_ns_q[idx_nx]);
                        end else if (state_q == ST_EMIT) begin
                            state_q <= ST_XMTR;
                            idx_q   <= 6'h00;
                            sh_q    <= xmtr_word(xmtr_w0_q[0], xmtr_w1_q[0]);
                        end else if (idx_q != num_xmtr) begin
                            idx_q <= idx_nx;
                            sh_q  <= xmtr_word(xmtr_w0_q[idx_nx],
                                               xmtr_w1_q[idx_nx]);
                        end else begin
                            state_q <= ST_REL;
                            left_q  <= `TMG_TAIL_BYTES;
                            sh_q    <= {rls_q, 2'b11, 80'hFFFFFFFFFFFFFFFFFFFF};
                        end
                    end
                end
                ST_REL: begin
                    if (emitting && left_q == 4'h1) begin
                        state_q <= ST_CRC;
                        left_q  <= `TMG_TAIL_BYTES;
                    end
                end
                ST_CRC: begin
                    if (emitting && left_q == 4'h1) begin
                        state_q <= ST_IDLE;
                        group_q <= (group_q >= top_group_q)
                                 ? 7'h00 : group_q + 7'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign reg_rdata        = rdata_q;
    assign out_data         = out_data_q;
    assign out_valid        = out_valid_q;
    assign out_seg_start    = out_seg_start_q;
    assign out_marker       = out_marker_q;
    assign out_last         = out_last_q;
    assign seg_payload_type = `TMG_PAYLOAD_TYPE;
    assign seg_source_id    = `TMG_SOURCE_ID;
    assign gen_busy         = (state_q != ST_IDLE);
endmodule // tmg_payload_gen
`default_nettype wire

// ---- testbench/tmg_payload_checker.sv ----
// Assertion checker for the payload generator output stream.
`default_nettype none
module tmg_payload_checker (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [7:0]  out_data,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic        out_seg_start,
    input wire logic        out_marker,
    input wire logic        out_last,
    input wire logic [6:0]  seg_payload_type,
    input wire logic [31:0] seg_source_id
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q;
    logic [15:0] len_q;
    logic        open_q;
    wire         acc = out_valid && out_ready;
    wire  [15:0] idx = out_marker ? 16'h0000 : cnt_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Byte index inside the structure; the marker byte restarts it.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q  <= 16'h0000;
            len_q  <= 16'h0000;
            open_q <= 1'b0;
        end else if (acc) begin
            cnt_q  <= idx + 16'h0001;
            open_q <= !out_last;
            if (idx == 16'h0000)
                len_q[15:8] <= out_data;
            if (idx == 16'h0001)
                len_q[7:0] <= out_data;
        end
    end
    property p_seg_ids;
        seg_payload_type == 7'h4C && seg_source_id == 32'h00000000;
    endproperty
    a_seg_ids: assert property (p_seg_ids) else $error("segment ids");
    property p_marker_first;
        out_valid && out_marker |-> out_seg_start && !open_q;
    endproperty
    a_marker_first: assert property (p_marker_first)
        else $error("marker not on structure start");
    property p_marker_once;
        acc && out_marker |=> !out_marker [*8];
    endproperty
    a_marker_once: assert property (p_marker_once)
        else $error("marker repeated");
    property p_length;
        acc && out_last |-> idx + 16'h0001 == len_q;
    endproperty
    a_length: assert property (p_length) else $error("length field");
    property p_version;
        acc && idx == 16'h0002 |-> out_data == 8'h00;
    endproperty
    a_version: assert property (p_version) else $error("version");
    property p_reps;
        acc && idx == 16'h0003 |-> out_data[4] && out_data[0]
            && out_data[7:4] <= 4'h9 && out_data[3:0] <= 4'h9;
    endproperty
    a_reps: assert property (p_reps) else $error("rep count");
    property p_override;
        acc && idx == 16'h000A |-> out_data[4:2] inside {3'b000, 3'b111};
    endproperty
    a_override: assert property (p_override) else $error("override");
    property p_carrier;
        acc && idx == 16'h000B |-> out_data[7:6] != 2'b10
            && out_data[5:0] == 6'h3F;
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier");
    property p_rel_resv;
        acc && idx > 16'h000B && idx == len_q - 16'h0003
            |-> out_data[1:0] == 2'b11;
    endproperty
    a_rel_resv: assert property (p_rel_resv) else $error("release pad");
    c_last: cover property (acc && out_last);
    c_stall: cover property (out_valid && !out_ready);
    c_override: cover property (acc && idx == 16'h000A && out_data[2]);
endmodule // tmg_payload_checker
bind tmg_payload_gen tmg_payload_checker u_tmg_payload_checker (
    .core_clk(core_clk), .reset(reset), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready),
    .out_seg_start(out_seg_start), .out_marker(out_marker),
    .out_last(out_last), .seg_payload_type(seg_payload_type),
    .seg_source_id(seg_source_id));
`default_nettype wire

// ---- testbench/tmg_sink_model.sv ----
// Downstream segment consumer that stores each byte with its marker and segment-start flags.
`default_nettype none
module tmg_sink_model (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       stall,
    input  wire logic [7:0] out_data,
    input  wire logic       out_valid,
    input  wire logic       out_seg_start,
    input  wire logic       out_marker,
    output var  logic       out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0]  mem [0:4095];
    int          n_rx;
    logic [31:0] rnd_q;
    // Random back-pressure forces the generator to hold its bytes.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_ready <= 1'b0;
            n_rx <= 0;
            rnd_q <= 32'h1357ACE1;
        end else begin
            rnd_q <= {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1]};
            out_ready <= !stall || rnd_q[0];
            if (out_valid && out_ready) begin
                mem[n_rx[11:0]] <= {out_marker, out_seg_start, out_data};
                n_rx <= n_rx + 1;
            end
        end
    end
endmodule // tmg_sink_model
`default_nettype wire

// ---- testbench/timing_mgmt_payload_codec_tb.sv ----
// Self-checking bench for the timing payload generator.
`include "tmg_defs.vh"
`default_nettype none
module timing_mgmt_payload_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic [8:0]  reg_addr = 9'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] tai_seconds = 32'h00000000;
    logic [31:0] tai_nanosec = 32'h00000000;
    logic        stall = 1'b0;
    wire  [31:0] reg_rdata;
    wire  [7:0]  out_data;
    wire         out_valid;
    wire         out_ready;
    wire         out_seg_start;
    wire         out_marker;
    wire         out_last;
    wire         gen_busy;
    wire  [6:0]  seg_payload_type;
    wire  [31:0] seg_source_id;
    int          n_errors = 0;
    int          n_tests = 0;
    logic [31:0] seed = 32'h3E043083;
    logic [7:0]  exp_q [$];
    logic [31:0] got;
    tmg_payload_gen u_tmg_payload_gen (.core_clk(core_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tai_seconds(tai_seconds),
        .tai_nanosec(tai_nanosec), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready),
        .out_seg_start(out_seg_start), .out_marker(out_marker),
        .out_last(out_last), .seg_payload_type(seg_payload_type),
        .seg_source_id(seg_source_id), .gen_busy(gen_busy));
    tmg_sink_model u_tmg_sink_model (.core_clk(core_clk), .reset(reset),
        .stall(stall), .out_data(out_data), .out_valid(out_valid),
        .out_seg_start(out_seg_start), .out_marker(out_marker),
        .out_ready(out_ready));
    always #10 core_clk = ~core_clk;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [3:0] rep(input logic [31:0] r);
        return 4'(2 * (r % 5) + 1);
    endfunction
    function automatic logic [15:0] crc(input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c = c ^ {exp_q[i], 8'h00};
            for (int b = 0; b < 8; b++)
                c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        end
        return c;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [8:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
        if (e !== 32'hFFFFFFFF)
            cmp(got, e, "register read");
        @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        int n, base, ne, nt, k;
        logic [31:0] c0, c1, s, ns, w0, w1, ts, tn, grp;
        logic [95:0] hdr;
        logic [63:0] ent;
        logic [15:0] tail;
        logic [8:0]  bad_a [5];
        logic [31:0] bad_d [5];
        bad_a = '{`TMG_A_CFG0, `TMG_A_CFG0, `TMG_A_CFG1, `TMG_A_CFG1,
                  `TMG_A_EMIT_BASE + 9'h001};
        bad_d = '{32'h00000012, 32'h00000021, 32'h00800000, 32'h10000000,
                  32'h3B9ACA00};
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rdc(`TMG_A_CFG0, 32'h00000011);
        rdc(`TMG_A_CFG1, 32'h00000000);
        rdc(`TMG_A_CFG2, 32'h00057800);
        rdc(`TMG_A_STATUS, 32'h00000000);
        rdc(`TMG_A_GROUP, 32'h00000000);
        rdc(9'h00F, 32'h00000000);
        for (int j = 0; j < 5; j++) begin
            wr(bad_a[j], bad_d[j]);
            rdc(`TMG_A_STATUS, 32'h00000002);
            wr(`TMG_A_CTRL, 32'h00000002);
            rdc(`TMG_A_STATUS, 32'h00000000);
            rdc(bad_a[j], j < 2 ? 32'h00000011 : 32'h00000000);
        end
        grp = 32'h0;
        for (int p = 0; p < 5; p++) begin
            ne = p == 0 ? 63 : (p == 4 ? 0 : int'(xs() % 4));
            nt = p == 0 ? 63 : (p == 4 ? 0 : int'(xs() % 4));
            s = xs();
            c0 = (xs() & 32'h3FFFFF00) | {24'h000000, rep(xs()), rep(xs())};
            c1 = {3'b000, s[12:11] == 2'b10 ? 2'b01 : s[12:11], s[26:25],
                  p[0] ? 3'b111 : 3'b000, nt[5:0], ne[5:0], s[9:0]};
            ts = xs();
            tn = xs() % 32'd1000000000;
            tai_seconds <= ts;
            tai_nanosec <= tn;
            wr(`TMG_A_CFG0, c0);
            wr(`TMG_A_CFG1, c1);
            wr(`TMG_A_CFG2, p == 0 ? 32'h00057802 : 32'h00001002);
            n = 32 + 8 * ne + 8 * nt;
            hdr = {n[15:0], 8'h00, c0[3:0], c0[7:4], c0[11:8], c0[15:12],
                   c0[20:16], c0[22:21], c0[29:23],
                   c1[7:0], c1[9:8], c1[15:10], c1[21:16],
                   grp[6:0], c1[24:22], c1[26:25], c1[28:27],
                   6'h3F};
            exp_q.delete();
            for (int b = 11; b >= 0; b--)
                exp_q.push_back(hdr[8 * b +: 8]);
            s = xs() >> 1;
            ns = xs() % 32'd1000000000;
            for (int i = 0; i <= ne + nt + 1; i++) begin
                if (i <= ne && xs() % 2 == 1) begin
                    s = s + 32'h1;
                    ns = xs() % 32'd1000000000;
                end
                w0 = xs() & 32'h1FFFFFFF;
                w1 = xs() & 32'h0000003F;
                ent = i <= ne ? {s, ns} : {w0[12:0], w0[28:13], w1[3:0],
                                           w1[5:4], 29'h1FFFFFFF};
                for (int b = 7; b >= 0; b--)
                    exp_q.push_back(ent[8 * b +: 8]);
                wr(i <= ne ? `TMG_A_EMIT_BASE + 9'(2 * i)
                           : `TMG_A_XMTR_BASE + 9'(2 * (i - ne - 1)),
                   i <= ne ? s : w0);
                wr(i <= ne ? `TMG_A_EMIT_BASE + 9'(2 * i + 1)
                           : `TMG_A_XMTR_BASE + 9'(2 * (i - ne - 1) + 1),
                   i <= ne ? ns : w1);
            end
            tail = {ts[3:0], tn[29:20], 2'b11};
            exp_q.push_back(tail[15:8]);
            exp_q.push_back(tail[7:0]);
            tail = crc(exp_q.size());
            exp_q.push_back(tail[15:8]);
            exp_q.push_back(tail[7:0]);
            rdc(`TMG_A_GROUP, grp);
            stall <= p[0];
            base = u_tmg_sink_model.n_rx;
            wr(`TMG_A_CTRL, 32'h00000001);
            // The last byte may still wait on the sink after busy drops.
            for (k = 0; k < 20000 && (gen_busy || out_valid || k < 4); k++)
                rdc(`TMG_A_STATUS, 32'hFFFFFFFF);
            cmp(32'(u_tmg_sink_model.n_rx - base), 32'(n), "byte count");
            for (int i = 0; i < n; i++) begin
                got = {22'h0, u_tmg_sink_model.mem[base + i]};
                cmp(got[7:0], exp_q[i], "byte");
                cmp(got[9:8], {i == 0, i % (p == 0 ? 1400 : 16) == 0},
                    "segment flags");
            end
            grp = grp == 32'h2 ? 32'h0 : grp + 32'h1;
        end
        // Entry one earlier than entry zero must abort with no bytes.
        wr(`TMG_A_CFG1, 32'h00000400);
        wr(`TMG_A_EMIT_BASE, 32'h00000005);
        wr(`TMG_A_EMIT_BASE + 9'h001, 32'h00000000);
        wr(`TMG_A_EMIT_BASE + 9'h002, 32'h00000004);
        wr(`TMG_A_EMIT_BASE + 9'h003, 32'h00000000);
        base = u_tmg_sink_model.n_rx;
        wr(`TMG_A_CTRL, 32'h00000001);
        got = 32'h0;
        for (k = 0; k < 50 && got[1] !== 1'b1; k++)
            rdc(`TMG_A_STATUS, 32'hFFFFFFFF);
        cmp({31'h0, got[1]}, 32'h1, "order error");
        cmp(32'(u_tmg_sink_model.n_rx - base), 32'h0, "bytes sent");
        tally_and_finish();
    end
endmodule // timing_mgmt_payload_codec_tb
`default_nettype wire
